// *** sdram_params.svh ***
// Constants for the SDRAM mode fields, burst codes and array geometry
`ifndef SDRAM_PARAMS_SVH
`define SDRAM_PARAMS_SVH
`define MODE_BL_LSB 0
`define MODE_BL_MSB 2
`define MODE_BT_BIT 3
`define MODE_CL_LSB 4
`define MODE_CL_MSB 6
`define MODE_OP_LSB 7
`define MODE_OP_MSB 8
`define MODE_WB_BIT 9
`define MODE_RESET 12'h000
`define BL_1 3'h0
`define BL_2 3'h1
`define BL_4 3'h2
`define BL_8 3'h3
`define BL_PAGE 3'h7
`define CL_2 3'h2
`define CL_3 3'h3
`define NUM_BANKS 4
`define NUM_ROWS 4096
`define NUM_COLS 256
`define DATA_W 16
`endif

// *** sdram_pkg.sv ***
// Types shared by the SDRAM model
package sdram_pkg;
  // Command code {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    cmd_inhibit_type = 4'h8,
    cmd_nop_type = 4'h7,
    cmd_active_type = 4'h3,
    cmd_read_type = 4'h5,
    cmd_write_type = 4'h4,
    cmd_term_type = 4'h6,
    cmd_pre_type = 4'h2,
    cmd_ref_type = 4'h1,
    cmd_lmr_type = 4'h0
  } cmd_type;
endpackage

// *** burst_addr_gen.sv ***
// Column address generator for one burst step
`timescale 1ns/1ns
`include "sdram_params.svh"
module burst_addr_gen (
  input wire logic [7:0] start_col,
  input wire logic [7:0] count,
  input wire logic [2:0] burst_len,
  input wire logic interleaved,
  output logic [7:0] col
);
  logic [7:0] mask;
  logic [7:0] seq;
  logic [7:0] ilv;
  // Wrap mask picks block bits versus in-block bits
  always_comb begin
    unique case (burst_len)
      `BL_2: mask = 8'h01;
      `BL_4: mask = 8'h03;
      `BL_8: mask = 8'h07;
      `BL_PAGE: mask = 8'hff;
      default: mask = 8'h00;
    endcase
    seq = start_col + count;
    ilv = start_col ^ count;
    // Upper block bits fixed, low bits ordered by type
    col = (start_col & ~mask) | ((interleaved ? ilv : seq) & mask); // [RULE16] [RULE17] [RULE18]
  end
endmodule

// *** sdram_core.sv ***
// SDRAM device core: mode register, banks, burst addressing, read latency
//
// How it works
// RULE1 - All inputs are sampled on the rising edge of sys_clk only.
// RULE2 - Four banks, 4096 rows by 256 columns of 16-bit words.
// RULE3 - Controller opens a row with ACTIVE before any READ or WRITE.
// RULE4 - ACTIVE takes bank from bank selects, row from address bits 0-11.
// RULE5 - READ or WRITE takes starting column from address bits 0-7.
// RULE6 - Controller holds mask and clock enable high during power-up.
// RULE7 - Controller waits 100 us issuing only inhibit or NOP.
// RULE8 - Controller then precharges all banks to idle.
// RULE9 - Controller performs at least two auto refreshes before mode load.
// RULE10 - Controller loads the mode register before operational commands.
// RULE11 - At least one NOP follows a mode register load.
// RULE12 - Mode word changes only on LOAD MODE REGISTER.
// RULE13 - Mode fields: length, type, latency, operating mode, write burst, reserved.
// RULE14 - Mode is loaded only with all banks idle, then waits.
// RULE15 - Lengths 1,2,4,8 both types; full page sequential only.
// RULE16 - Burst wraps inside the block chosen by upper column bits.
// RULE17 - Full page wraps within 256 columns until burst terminate.
// RULE18 - Sequential increments modulo block; interleaved XORs start with count.
// RULE19 - Read latency two or three; data valid at edge n plus latency.
// RULE20 - Normal operation only when both operating mode bits are zero.
// RULE21 - Write burst bit set makes every write single location.
// RULE22 - Controller never programs reserved encodings.
// RULE23 - Two clocks from mode load to ACTIVE or REFRESH.
// RULE24 - Burst type 0 sequential, 1 interleaved.
// RULE25 - Length codes 0-3 give 1,2,4,8, 7 full page; latency 2 or 3.
`timescale 1ns/1ns
`include "sdram_params.svh"
module sdram_core #(
  parameter int ROWS = `NUM_ROWS,
  parameter int COLS = `NUM_COLS,
  parameter int BANKS = `NUM_BANKS,
  parameter int DW = `DATA_W
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic bank_select_low,
  input wire logic bank_select_high,
  input wire logic [11:0] addr,
  input wire logic [1:0] dqm,
  input wire logic [DW-1:0] dq_in,
  output logic [DW-1:0] dq_out,
  output logic dq_oe,
  output logic [11:0] mode_word
);
  // ----------------------------------------------------------------
  // Storage and command decode
  // ----------------------------------------------------------------
  logic [DW-1:0] mem [BANKS*ROWS*COLS]; // [RULE2]
  logic [3:0] cmd_raw;
  logic [1:0] cmd_bank;
  sdram_pkg::cmd_type cmd;
  assign cmd_raw = cs_n ? 4'h8 : {1'b0, ras_n, cas_n, we_n};
  assign cmd = sdram_pkg::cmd_type'(cmd_raw);
  assign cmd_bank = {bank_select_high, bank_select_low};

  // ----------------------------------------------------------------
  // Mode register and open rows
  // ----------------------------------------------------------------
  logic [11:0] operating_configuration_word_ff, nxt_operating_configuration_word;
  logic [11:0] row_ff [BANKS];
  logic [11:0] nxt_row [BANKS];
  logic [2:0] burst_length_field;
  logic burst_type_bit;
  logic [2:0] read_latency_field;
  logic operating_mode_bit_low;
  logic operating_mode_bit_high;
  logic write_burst_mode_bit;
  logic normal_mode;
  logic cmd_valid;
  assign cmd_valid = cke;
  // Field split of the mode word
  assign burst_length_field = operating_configuration_word_ff[`MODE_BL_MSB:`MODE_BL_LSB]; // [RULE13]
  assign burst_type_bit = operating_configuration_word_ff[`MODE_BT_BIT]; // [RULE24]
  assign read_latency_field = operating_configuration_word_ff[`MODE_CL_MSB:`MODE_CL_LSB];
  assign operating_mode_bit_low = operating_configuration_word_ff[`MODE_OP_LSB];
  assign operating_mode_bit_high = operating_configuration_word_ff[`MODE_OP_MSB];
  assign write_burst_mode_bit = operating_configuration_word_ff[`MODE_WB_BIT];
  assign normal_mode = !operating_mode_bit_low && !operating_mode_bit_high; // [RULE20]

  // Next mode word and row latches
  always_comb begin
    nxt_operating_configuration_word = operating_configuration_word_ff;
    for (int b = 0; b < BANKS; b++) begin
      nxt_row[b] = row_ff[b];
    end
    if (cmd_valid && cmd == sdram_pkg::cmd_lmr_type) begin
      nxt_operating_configuration_word = addr; // [RULE12]
    end
    if (cmd_valid && cmd == sdram_pkg::cmd_active_type) begin
      nxt_row[cmd_bank] = addr; // [RULE4]
    end
  end

  // Registers, sampled on the rising edge only
  always_ff @(posedge sys_clk) begin // [RULE1]
    if (rst) begin
      operating_configuration_word_ff <= `MODE_RESET;
      for (int b = 0; b < BANKS; b++) begin
        row_ff[b] <= 12'h000;
      end
    end else begin
      operating_configuration_word_ff <= nxt_operating_configuration_word;
      row_ff <= nxt_row;
    end
  end

  // ----------------------------------------------------------------
  // Burst engine
  // ----------------------------------------------------------------
  logic active_ff, nxt_active;
  logic is_write_ff, nxt_is_write;
  logic [1:0] bank_ff, nxt_bank;
  logic [7:0] start_ff, nxt_start;
  logic [7:0] count_ff, nxt_count;
  logic [2:0] len_code_ff, nxt_len_code;
  logic [8:0] burst_len_words;
  logic [7:0] gen_start;
  logic [7:0] gen_count;
  logic [7:0] col;
  logic [2:0] eff_len;
  logic new_cmd;
  logic stop_cmd;
  logic start_write;

  assign new_cmd = cmd_valid && normal_mode &&
                   (cmd == sdram_pkg::cmd_read_type || cmd == sdram_pkg::cmd_write_type);
  // Burst terminate or precharge ends the running burst
  assign stop_cmd = cmd_valid && (cmd == sdram_pkg::cmd_term_type ||
                                  cmd == sdram_pkg::cmd_pre_type);
  assign start_write = (cmd == sdram_pkg::cmd_write_type);
  // Write burst bit forces single-location writes
  assign eff_len = (start_write && write_burst_mode_bit) ? `BL_1 : burst_length_field; // [RULE21]
  // A new command starts at count zero; otherwise continue current burst
  assign gen_start = new_cmd ? addr[7:0] : start_ff; // [RULE5]
  assign gen_count = new_cmd ? 8'h00 : count_ff;

  // Length in words for the active code
  always_comb begin
    unique case (len_code_ff)
      `BL_1: burst_len_words = 9'h001; // [RULE25]
      `BL_2: burst_len_words = 9'h002;
      `BL_4: burst_len_words = 9'h004;
      `BL_8: burst_len_words = 9'h008; // [RULE15]
      default: burst_len_words = 9'h000; // full page: runs until terminated
    endcase
  end

  burst_addr_gen u_gen (
    .start_col(gen_start),
    .count(gen_count),
    .burst_len(new_cmd ? eff_len : len_code_ff),
    .interleaved(burst_type_bit && (new_cmd ? eff_len : len_code_ff) != `BL_PAGE),
    .col(col)
  );

  // Flat array index, sized from the bank, row and column counts
  localparam int BW = $clog2(BANKS);
  localparam int RW = $clog2(ROWS);
  localparam int CW = $clog2(COLS);
  logic [1:0] acc_bank;
  logic acc_en;
  logic acc_write;
  logic [11:0] acc_row;
  logic [BW+RW+CW-1:0] acc_index;
  assign acc_bank = new_cmd ? cmd_bank : bank_ff;
  // The edge that stops a burst does no access of its own
  assign acc_en = new_cmd || (active_ff && !stop_cmd); // [RULE17]
  assign acc_write = new_cmd ? start_write : is_write_ff;
  assign acc_row = row_ff[acc_bank];
  assign acc_index = {acc_bank[BW-1:0], acc_row[RW-1:0], col[CW-1:0]}; // [RULE2]

  // Burst sequencing
  always_comb begin
    nxt_active = active_ff;
    nxt_is_write = is_write_ff;
    nxt_bank = bank_ff;
    nxt_start = start_ff;
    nxt_count = count_ff;
    nxt_len_code = len_code_ff;
    if (new_cmd) begin
      nxt_is_write = start_write;
      nxt_bank = cmd_bank;
      nxt_start = addr[7:0];
      nxt_len_code = eff_len;
      nxt_count = 8'h01;
      // Reserved length codes behave as a single word
      nxt_active = (eff_len inside {`BL_2, `BL_4, `BL_8, `BL_PAGE});
    end else if (stop_cmd) begin
      nxt_active = 1'b0; // [RULE17]
    end else if (active_ff) begin
      nxt_count = count_ff + 8'h01;
      if (len_code_ff != `BL_PAGE && {1'b0, count_ff} + 9'h001 >= burst_len_words) begin
        nxt_active = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      active_ff <= 1'b0;
      is_write_ff <= 1'b0;
      bank_ff <= 2'h0;
      start_ff <= 8'h00;
      count_ff <= 8'h00;
      len_code_ff <= `BL_1;
    end else begin
      active_ff <= nxt_active;
      is_write_ff <= nxt_is_write;
      bank_ff <= nxt_bank;
      start_ff <= nxt_start;
      count_ff <= nxt_count;
      len_code_ff <= nxt_len_code;
    end
  end

  // Array write with byte mask, array read into the latency pipe
  logic [DW-1:0] rd_word;
  logic rd_valid;
  always_ff @(posedge sys_clk) begin
    if (acc_en && acc_write) begin
      if (!dqm[0]) mem[acc_index][7:0] <= dq_in[7:0];
      if (!dqm[1]) mem[acc_index][15:8] <= dq_in[15:8];
    end
  end
  assign rd_word = mem[acc_index];
  assign rd_valid = acc_en && !acc_write;

  // ----------------------------------------------------------------
  // Read latency pipe
  // ----------------------------------------------------------------
  // Stage 0 is captured at the READ edge n; output stands after n+m-1
  logic [DW-1:0] pipe_d_ff [2];
  logic [DW-1:0] nxt_pipe_d [2];
  logic [1:0] pipe_v_ff, nxt_pipe_v;
  logic [DW-1:0] nxt_dq_out;
  logic nxt_dq_oe;
  logic cl3;
  assign cl3 = (read_latency_field == `CL_3);
  always_comb begin
    nxt_pipe_d[0] = rd_word;
    nxt_pipe_v[0] = rd_valid;
    nxt_pipe_d[1] = pipe_d_ff[0];
    nxt_pipe_v[1] = pipe_v_ff[0];
    // Latency 2 uses one stage, latency 3 two stages
    nxt_dq_out = cl3 ? pipe_d_ff[1] : pipe_d_ff[0]; // [RULE19]
    nxt_dq_oe = cl3 ? pipe_v_ff[1] : pipe_v_ff[0];
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pipe_d_ff[0] <= '0;
      pipe_d_ff[1] <= '0;
      pipe_v_ff <= 2'h0;
      dq_out <= '0;
      dq_oe <= 1'b0;
      mode_word <= `MODE_RESET;
    end else begin
      pipe_d_ff <= nxt_pipe_d;
      pipe_v_ff <= nxt_pipe_v;
      dq_out <= nxt_dq_out;
      dq_oe <= nxt_dq_oe;
      mode_word <= nxt_operating_configuration_word;
    end
  end
endmodule

// *** sdram_core_monitor.sv ***
// Port checker for the SDRAM core
`timescale 1ns/1ns
module sdram_core_monitor (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [11:0] addr,
  input wire logic dq_oe,
  input wire logic [11:0] mode_word
);
  // Command decode; reads only counted from an idle data bus
  logic lmr, rdx, rd, cl3;
  assign lmr = cke && {cs_n, ras_n, cas_n, we_n} == sdram_pkg::cmd_lmr_type;
  assign rdx = cke && {cs_n, ras_n, cas_n, we_n} == sdram_pkg::cmd_read_type && !dq_oe;
  assign rd = rdx && mode_word[8:7] == 2'h0;
  assign cl3 = mode_word[6:4] == 3'h3;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_lat2; !dq_oe ##1 dq_oe; endsequence
  sequence s_lat3; (!dq_oe) [*2] ##1 dq_oe; endsequence
  property p_load; lmr |=> mode_word == $past(addr); endproperty
  a_load: assert property (p_load) else $error("mode load lost");
  property p_hold; !lmr |=> $stable(mode_word); endproperty
  a_hold: assert property (p_hold) else $error("mode word moved");
  property p_cl2; rd && !cl3 |=> s_lat2; endproperty
  a_cl2: assert property (p_cl2) else $error("latency two wrong");
  property p_cl3; rd && cl3 |=> s_lat3; endproperty
  a_cl3: assert property (p_cl3) else $error("latency three wrong");
  property p_bl1; $rose(dq_oe) && mode_word[2:0] == 3'h0 |=> !dq_oe; endproperty
  a_bl1: assert property (p_bl1) else $error("length one wrong");
  property p_bl4; $rose(dq_oe) && mode_word[2:0] == 3'h2 |-> dq_oe [*4] ##1 !dq_oe; endproperty
  a_bl4: assert property (p_bl4) else $error("length four wrong");
  property p_bl8; $rose(dq_oe) && mode_word[2:0] == 3'h3 |-> dq_oe [*8] ##1 !dq_oe; endproperty
  a_bl8: assert property (p_bl8) else $error("length eight wrong");
  property p_off; rdx && mode_word[8:7] != 2'h0 |=> (!dq_oe) [*4]; endproperty
  a_off: assert property (p_off) else $error("read in test mode");
endmodule

// *** ctl_model.sv ***
// Memory controller model driving the command pins
`timescale 1ns/1ns
module ctl_model #(
  parameter int WAIT_CYC = 10000
) (
  input wire logic sys_clk,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic bank_select_low,
  output logic bank_select_high,
  output logic [11:0] addr,
  output logic [1:0] dqm,
  output logic [15:0] dq_in
);
  // Power-up levels
  initial begin
    cke = 1'b1;
    dqm = 2'h3;
    {cs_n, ras_n, cas_n, we_n} = 4'h8;
    {bank_select_high, bank_select_low, addr} = 14'h0000;
    dq_in = 16'h0000;
  end
  // One command per clock, launched just after the edge
  task cmd(input logic [3:0] c, input logic [13:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    {cs_n, ras_n, cas_n, we_n} <= c;
    {bank_select_high, bank_select_low, addr} <= a;
    dq_in <= d;
  endtask
  // Idle cycle; released address is the inverse of the address present at the call
  task dat(input logic [15:0] d);
    cmd(sdram_pkg::cmd_nop_type, ~{bank_select_high, bank_select_low, addr}, d);
  endtask
  task nop();
    dat(~dq_in);
  endtask
  task clk_en(input logic v);
    @(posedge sys_clk);
    cke <= v;
  endtask
  // Close all banks, load the mode word, two idle cycles
  task mode(input logic [11:0] m);
    cmd(sdram_pkg::cmd_pre_type, 14'h0400, ~dq_in);
    nop();
    cmd(sdram_pkg::cmd_lmr_type, {2'h0, m}, ~dq_in);
    nop();
    nop();
  endtask
  // Start-up wait, precharge all, two refreshes
  task start();
    repeat (WAIT_CYC) nop();
    dqm <= 2'h0;
    cmd(sdram_pkg::cmd_pre_type, 14'h0400, ~dq_in);
    repeat (2) begin
      nop();
      cmd(sdram_pkg::cmd_ref_type, 14'h0000, ~dq_in);
      repeat (6) nop();
    end
  endtask
endmodule

// *** test_sdram_core.sv ***
// Self-checking bench for the SDRAM core
`timescale 1ns/1ns
module test_sdram_core;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic cke, cs_n, ras_n, cas_n, we_n, bank_select_low, bank_select_high, dq_oe;
  logic [11:0] addr, mode_word, mw;
  logic [1:0] dqm, ba;
  logic [3:0] row;
  logic [7:0] s;
  logic [15:0] dq_in, dq_out;
  logic [15:0] rnd = 16'h005d;
  logic [15:0] mem [int];
  logic [11:0] modes [7] = '{12'h020, 12'h021, 12'h03a, 12'h02b, 12'h033, 12'h222, 12'h027};
  int err_count = 0;
  int compares = 0;
  int n;
  always #5 sys_clk = ~sys_clk;
  sdram_core #(.ROWS(16)) i_sdram_core (.sys_clk, .rst, .cke, .cs_n, .ras_n, .cas_n, .we_n,
    .bank_select_low, .bank_select_high, .addr, .dqm, .dq_in, .dq_out, .dq_oe, .mode_word);
  ctl_model i_ctl_model (.sys_clk, .cke, .cs_n, .ras_n, .cas_n, .we_n, .bank_select_low,
    .bank_select_high, .addr, .dqm, .dq_in);
  // ------------------------------
  // Expectations and checks
  // ------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic int blen(input logic [11:0] m);
    return m[2] ? 256 : 1 << m[1:0];
  endfunction
  function automatic logic [7:0] nth(input logic [7:0] st, input int i, input logic [11:0] m);
    logic [7:0] k;
    k = 8'(blen(m) - 1);
    return (st & ~k) | ((m[3] ? st ^ 8'(i) : st + 8'(i)) & k);
  endfunction
  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input int cnt);
    for (int i = 0; i < cnt; i++) begin
      rnd = lfsr(rnd);
      mem[nth(s, i, mw)] = rnd;
      if (i == 0)
        i_ctl_model.cmd(sdram_pkg::cmd_write_type, {ba, 4'h0, s}, rnd);
      else
        i_ctl_model.dat(rnd);
    end
  endtask
  task rd(input logic [7:0] st, input int cnt);
    int m;
    m = (mw[6:4] == 3'h3) ? 3 : 2;
    i_ctl_model.cmd(sdram_pkg::cmd_read_type, {ba, 4'h0, st}, rnd);
    for (int j = 0; j < m + cnt; j++) begin
      i_ctl_model.nop();
      #1;
      if (j >= m - 1 && j < m - 1 + cnt) begin
        chk(dq_oe, 1'b1);
        if (mem.exists(nth(st, j - m + 1, mw)))
          chk(dq_out, mem[nth(st, j - m + 1, mw)]);
      end else if (cnt == blen(mw))
        chk(dq_oe, 1'b0);
    end
  endtask
  task test_done();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence: each of the seven listed modes, then test mode and clock-enable refusal
  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    chk(dq_oe, 1'b0);
    chk(mode_word, 12'h000);
    {ba, row} = rnd[5:0];
    i_ctl_model.start();
    foreach (modes[k]) begin
      mw = modes[k];
      rnd = lfsr(rnd);
      i_ctl_model.mode(mw);
      chk(mode_word, mw);
      i_ctl_model.cmd(sdram_pkg::cmd_active_type, {ba, 8'h00, row}, rnd);
      repeat (2) i_ctl_model.nop();
      n = blen(mw);
      if (n == 256)
        s = 8'hfe;
      else if (!mw[9])
        s = rnd[7:0];
      wr(mw[9] ? 1 : (n == 256) ? 4 : n);
      if (n == 256)
        i_ctl_model.cmd(sdram_pkg::cmd_term_type, 14'h0000, rnd);
      i_ctl_model.nop();
      rd(s ^ 8'(n > 1), (n == 256) ? 3 : n);
    end
    mw = 12'h1a2;
    i_ctl_model.mode(mw);
    chk(mode_word, mw);
    i_ctl_model.cmd(sdram_pkg::cmd_active_type, {ba, 8'h00, row}, rnd);
    repeat (2) i_ctl_model.nop();
    i_ctl_model.cmd(sdram_pkg::cmd_read_type, {ba, 4'h0, s}, rnd);
    repeat (4) begin
      i_ctl_model.nop();
      #1;
      chk(dq_oe, 1'b0);
    end
    i_ctl_model.clk_en(1'b0);
    i_ctl_model.cmd(sdram_pkg::cmd_lmr_type, 14'h0021, rnd);
    i_ctl_model.nop();
    i_ctl_model.clk_en(1'b1);
    repeat (2) i_ctl_model.nop();
    chk(mode_word, mw);
    test_done();
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    test_done();
  end
endmodule
bind sdram_core sdram_core_monitor i_sdram_core_monitor (.sys_clk, .rst, .cke, .cs_n, .ras_n,
  .cas_n, .we_n, .addr, .dq_oe, .mode_word);
